// File: include/atb_pkg.sv
/*
 Package of the tri-state bus read port: result widths, bus width and the
 conversion timing count shared by the read port and its converter core.
 Assumes a single 250 MHz clock.
*/
package atb_pkg;
    localparam int unsigned RESULT_W     = 10;
    localparam int unsigned BUS_W        = 8;
    localparam int unsigned LOW_W        = 8;
    localparam int unsigned HIGH_W       = 2;
    localparam int unsigned STATUS_BIT   = 0;
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned CONV_TIME_NS = 40;
    localparam int unsigned CONV_CYCLES  = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
    localparam logic [9:0]  RESULT_RST   = 10'h000;
    localparam logic        DONE_RST     = 1'b1;
    typedef enum logic [1:0] {ATB_IDLE, ATB_BUSY, ATB_DONE} atb_state_t;
endpackage

// File: src/atb_conv_core.sv
/*
 Stand-in for the successive-approximation core: counts a conversion of
 fixed length and then latches the sample word presented to it.
 Assumes start is a clean single-cycle pulse on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module atb_conv_core #(
    parameter int unsigned CYCLES = atb_pkg::CONV_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Control
    input  wire logic       start,
    input  wire logic [9:0] sample,
    // Result
    output logic            done,
    output logic [9:0]      result
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        done_q;
    logic        done_d;
    logic [9:0]  res_q;
    logic [9:0]  res_d;

    // Next state; a new start restarts even a running conversion
    always_comb
    begin
        cnt_d  = cnt_q;
        done_d = done_q;
        res_d  = res_q;
        if (start)
        begin
            cnt_d  = 16'(CYCLES);
            done_d = 1'b0;
        end
        else if (!done_q)
        begin
            if (cnt_q <= 16'h0001)
            begin
                done_d = 1'b1;
                res_d  = sample;
                cnt_d  = 16'h0000;
            end
            else
            begin
                cnt_d = cnt_q - 16'h0001;
            end
        end
    end

    // Registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q  <= 16'h0000;
            done_q <= atb_pkg::DONE_RST;
            res_q  <= atb_pkg::RESULT_RST;
        end
        else
        begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
            res_q  <= res_d;
        end
    end

    assign done   = done_q;
    assign result = res_q;
endmodule
`default_nettype wire

// File: src/atb_read_port.sv
/*
 Bus-side read port of a 10-bit converter on a shared 8-bit data bus.
 Assumes all host strobes are pins from outside the clock domain; the bus
 wire level is resolved outside from data_out and the per-bit enables.
*/
// Operation
// [RULE1] Result and status lines use three-state drivers and release the bus.
// [RULE2] Host starts each measurement with a convert-start pulse.
// [RULE3] Status enable asserted drives the conversion status onto the bus.
// [RULE4] Status reads one when finished; host then drops status enable.
// [RULE5] Status enable dropped returns status line to high impedance.
// [RULE6] Low-byte enable drives result bits zero to seven, floats them after.
// [RULE7] High-byte enable drives result bits eight and nine, floats after.
// [RULE8] Host order: start, poll status, read low byte, read high bits.
// [RULE9] Host asserts at most one enable at a time.
`timescale 1ns/1ps
`default_nettype none
module atb_read_port #(
    parameter int unsigned CONV_CYCLES = atb_pkg::CONV_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Host strobes (pins)
    input  wire logic       convert_start,
    input  wire logic       status_output_enable,
    input  wire logic       low_byte_enable,
    input  wire logic       high_byte_enable,
    // Analog core sample word
    input  wire logic [9:0] sample_code,
    // Shared data bus, drive side
    output logic [7:0]      data_out,
    output logic [7:0]      data_oe,
    // Status observation
    output logic            conversion_done,
    output logic            bus_conflict
);
    // Three-stage samplers; stage one feeds only stage two
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] flt_q;
    logic [3:0] flt_d;
    logic [3:0] raw;

    assign raw = {high_byte_enable, low_byte_enable, status_output_enable, convert_start};

    // Filtered level updates when stages two and three agree
    always_comb
    begin
        flt_d = flt_q;
        for (int i = 0; i < 4; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                flt_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_q  <= 4'h0;
            s2_q  <= 4'h0;
            s3_q  <= 4'h0;
            flt_q <= 4'h0;
        end
        else
        begin
            s1_q  <= raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= flt_d;
        end
    end

    // Start pulse on the rising edge of the filtered strobe
    logic start_pulse;
    assign start_pulse = flt_d[0] & ~flt_q[0]; // [RULE2]

    logic       core_done;
    logic [9:0] core_result;

    atb_conv_core #(
        .CYCLES (CONV_CYCLES)
    ) u_core (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (start_pulse),
        .sample  (sample_code),
        .done    (core_done),
        .result  (core_result)
    );

    // Read sequencer; tracks the conversion through idle, busy and done
    atb_pkg::atb_state_t st_q;
    atb_pkg::atb_state_t st_d;

    // Next sequencer state; a start always wins over a finishing conversion
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            atb_pkg::ATB_IDLE:
            begin
                if (start_pulse)
                begin
                    st_d = atb_pkg::ATB_BUSY;
                end
            end
            atb_pkg::ATB_BUSY:
            begin
                if (core_done && !start_pulse)
                begin
                    st_d = atb_pkg::ATB_DONE;
                end
            end
            atb_pkg::ATB_DONE:
            begin
                if (start_pulse)
                begin
                    st_d = atb_pkg::ATB_BUSY;
                end
            end
            default:
            begin
                st_d = atb_pkg::ATB_IDLE; // Unused code recovers to idle
            end
        endcase
    end

    // Sequencer register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= atb_pkg::ATB_IDLE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Bus drive: data and enables both registered, set by filtered strobes
    logic [7:0] dout_q;
    logic [7:0] dout_d;
    logic [7:0] doe_q;
    logic [7:0] doe_d;
    logic       conf_q;
    logic       conf_d;
    logic [7:0] status_word;

    // Status is one once conversion has finished
    assign status_word = {7'h00, core_done}; // [RULE4]

    always_comb
    begin
        dout_d = 8'h00;
        doe_d  = 8'h00; // Bus released by default [RULE1]
        // Priority on contention keeps a single driver; the host must avoid it
        if (flt_d[1])
        begin
            dout_d = status_word;                 // [RULE3]
            doe_d[atb_pkg::STATUS_BIT] = 1'b1;    // Floats when enable drops [RULE5]
        end
        else if (flt_d[2])
        begin
            dout_d = core_result[atb_pkg::LOW_W-1:0]; // [RULE6]
            doe_d  = 8'hff;
        end
        else if (flt_d[3])
        begin
            dout_d = {6'h00, core_result[atb_pkg::RESULT_W-1:atb_pkg::LOW_W]}; // [RULE7]
            doe_d  = 8'h03;
        end
    end

    // Drive registers; enables and data switch on the same edge, no glitch
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dout_q <= 8'h00;
            doe_q  <= 8'h00;
        end
        else
        begin
            dout_q <= dout_d;
            doe_q  <= doe_d;
        end
    end

    // Overlap detector; flags host misuse only, the drive priority stays
    always_comb
    begin
        conf_d = 1'b0;
        if ((flt_d[1] && flt_d[2]) || (flt_d[1] && flt_d[3]) || (flt_d[2] && flt_d[3]))
        begin
            conf_d = 1'b1; // [RULE9]
        end
    end

    // Overlap flag register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            conf_q <= 1'b0;
        end
        else
        begin
            conf_q <= conf_d; // Host overlap flag [RULE9]
        end
    end

    // Outputs straight from flip-flops

    assign data_out        = dout_q;
    assign data_oe         = doe_q;
    assign conversion_done = core_done;
    assign bus_conflict    = conf_q;
endmodule
`default_nettype wire

// File: verif/atb_host_bus.sv
/*
 Host-side wire model of the shared data bus.
 Assumes per-bit drive enables from the read port.
*/
`timescale 1ns/1ps
`default_nettype none
module atb_host_bus (
    // Clock
    input  wire logic       clk,
    // Port drive side
    input  wire logic [7:0] data_out,
    input  wire logic [7:0] data_oe,
    // Resolved wire
    output logic [7:0]      bus
);
    logic [7:0] last_q = 8'h00;
    // Floating bits toggle each cycle so a stale value never holds two cycles running
    always_comb bus = (data_oe & data_out) | (~data_oe & ~last_q);
    always_ff @(posedge clk) last_q <= bus;
endmodule
`default_nettype wire

// File: verif/atb_read_port_props.sv
/*
 Pin-level assertions of the read port.
 Assumes host enables are held at least five cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module atb_read_port_props #(
    parameter int unsigned CONV_CYCLES = 10
) (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       convert_start,
    input wire logic       status_output_enable,
    input wire logic       low_byte_enable,
    input wire logic       high_byte_enable,
    input wire logic [9:0] sample_code,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    input wire logic       conversion_done,
    input wire logic       bus_conflict
);
    localparam int CH = CONV_CYCLES - 7;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Enable patterns held long enough to clear the pin filter
    sequence sts_s; (status_output_enable && !low_byte_enable && !high_byte_enable)[*5]; endsequence
    sequence low_s; (!status_output_enable && low_byte_enable && !high_byte_enable)[*5]; endsequence
    sequence hi_s; (!status_output_enable && !low_byte_enable && high_byte_enable)[*5]; endsequence
    sequence idle_s; (!status_output_enable && !low_byte_enable && !high_byte_enable)[*5]; endsequence
    chk_status_drive: assert property (sts_s |-> data_oe == 8'h01)
        else $error("status not driven");
    chk_status_done: assert property (sts_s ##0 $past(conversion_done) |-> data_out[0])
        else $error("status value wrong");
    chk_status_float: assert property ($fell(status_output_enable) && !low_byte_enable
        && !high_byte_enable |-> ##[2:4] data_oe == 8'h00)
        else $error("status not released");
    chk_low_drive: assert property (low_s |-> data_oe == 8'hff)
        else $error("low byte not driven");
    chk_high_drive: assert property (hi_s |-> data_oe == 8'h03)
        else $error("high bits not driven");
    chk_bus_release: assert property (idle_s |-> data_oe == 8'h00)
        else $error("bus not released");
    chk_start_busy: assert property ($rose(convert_start) |-> ##[1:4] !conversion_done)
        else $error("start not seen");
    chk_conv_length: assert property ($fell(conversion_done)
        |-> !conversion_done[*8] ##[1:CH] conversion_done)
        else $error("conversion length wrong");
    chk_conflict_flag: assert property ((status_output_enable && low_byte_enable)[*5]
        |-> bus_conflict && data_oe == 8'h01)
        else $error("conflict not handled");
endmodule
bind atb_read_port atb_read_port_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (
    .clk(clk), .reset_n(reset_n), .convert_start(convert_start),
    .status_output_enable(status_output_enable), .low_byte_enable(low_byte_enable),
    .high_byte_enable(high_byte_enable), .sample_code(sample_code), .data_out(data_out),
    .data_oe(data_oe), .conversion_done(conversion_done), .bus_conflict(bus_conflict));
`default_nettype wire

// File: verif/atb_read_port_tb_top.sv
/*
 Testbench of the read port: host pin sequences with expected bus values.
 Assumes the default ten-cycle conversion.
*/
`timescale 1ns/1ps
`default_nettype none
module atb_read_port_tb_top;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       convert_start, status_output_enable, low_byte_enable, high_byte_enable;
    logic [9:0] sample_code;
    logic [7:0] data_out, data_oe, bus;
    logic       conversion_done, bus_conflict;
    logic [9:0] codes [3] = '{10'h2a5, 10'h3ff, 10'h000};
    int         error_cnt = 0;
    int         checks_done = 0;
    // Clock and design
    always #2 clk = ~clk;
    atb_read_port #(.CONV_CYCLES(10)) dut (.clk(clk), .reset_n(reset_n),
        .convert_start(convert_start), .status_output_enable(status_output_enable),
        .low_byte_enable(low_byte_enable), .high_byte_enable(high_byte_enable),
        .sample_code(sample_code), .data_out(data_out), .data_oe(data_oe),
        .conversion_done(conversion_done), .bus_conflict(bus_conflict));
    atb_host_bus u_host (.clk(clk), .data_out(data_out), .data_oe(data_oe), .bus(bus));
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Pins {start, status, low, high}, held n cycles, sampled settled
    task automatic pins(input logic [3:0] p, input int n);
        @(posedge clk);
        {convert_start, status_output_enable, low_byte_enable, high_byte_enable} <= p;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic poll;
        int i;
        for (i = 0; i < 40 && !(bus[0] === 1'b1 && data_oe === 8'h01); i++)
            pins(4'h4, 1);
        if (i == 40)
        begin
            error_cnt++;
            stop_test();
        end
    endtask
    // Main sequence
    initial
    begin
        {convert_start, status_output_enable, low_byte_enable, high_byte_enable} = 4'h0;
        sample_code = 10'h000;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        pins(4'h0, 5);
        cmp8(data_oe, 8'h00);
        cmp8({7'h00, conversion_done}, 8'h01);
        foreach (codes[k])
        begin
            sample_code <= codes[k];
            pins(4'h8, 3);
            pins(4'h4, 5);
            cmp8(data_oe, 8'h01);
            cmp8(bus & 8'h01, 8'h00);
            poll();
            sample_code <= ~codes[k];
            pins(4'h0, 5);
            cmp8(data_oe, 8'h00);
            pins(4'h2, 5);
            cmp8(bus, codes[k][7:0]);
            cmp8(data_oe, 8'hff);
            pins(4'h0, 5);
            cmp8(data_oe, 8'h00);
            pins(4'h1, 5);
            cmp8(bus & 8'h03, {6'h00, codes[k][9:8]});
            cmp8(data_oe, 8'h03);
            pins(4'h0, 5);
            cmp8(data_oe, 8'h00);
        end
        pins(4'h6, 5);
        cmp8({7'h00, bus_conflict}, 8'h01);
        cmp8(data_oe, 8'h01);
        pins(4'h0, 5);
        stop_test();
    end
endmodule
`default_nettype wire
